// ===== core/cps_map.svh
// Purpose: constants for the configuration port selector and scrubber
// Assumes: core clock of 50 MHz
// Notes: timing counts derive from times in ns
`ifndef CPS_MAP_SVH
`define CPS_MAP_SVH
// ***********************************
// timing
// ***********************************
`define CPS_CLK_NS 20
`define CPS_BOOT_CLK_NS 160
`define CPS_BOOT_HALF ((`CPS_BOOT_CLK_NS) / (2 * `CPS_CLK_NS))
// ***********************************
// boot memory access
// ***********************************
`define CPS_READ_CMD 8'h03
`define CPS_PRIMARY_ADDR 24'h00_0000
`define CPS_GOLDEN_ADDR 24'h10_0000
`define CPS_CMD_BITS 6'd32
// ***********************************
// defaults and check constants
// ***********************************
`define CPS_KEY_DEFAULT 32'h5a3c_c3a5
`define CPS_VERSION_DEFAULT 8'h01
`define CPS_CRC_POLY 32'h04c1_1db7
`define CPS_CRC_INIT 32'hffff_ffff
`endif

// ===== core/cps_pkg.sv
// Purpose: types for the configuration port selector and scrubber
// Assumes: nothing
// Notes: state and width codes are fixed binary
`default_nettype none
package cps_pkg;
	typedef enum logic [2:0] {
		ST_POR = 3'h0, ST_SLAVE_WAIT = 3'h1, ST_SLAVE_LOAD = 3'h2, ST_MASTER = 3'h3,
		ST_SCAN = 3'h4, ST_FINISH = 3'h5, ST_USER = 3'h6, ST_FAIL = 3'h7
	} cps_state_t;
	typedef enum logic [2:0] {
		SC_IDLE = 3'h0, SC_READ = 3'h1, SC_WAIT = 3'h2, SC_CRC = 3'h3
	} cps_scrub_t;
	typedef enum logic [2:0] {
		PORT_NONE = 3'h0, PORT_SERIAL = 3'h1, PORT_I2C = 3'h2, PORT_I3C = 3'h3,
		PORT_MASTER = 3'h4, PORT_SCAN = 3'h5
	} cps_port_t;
	// data lines per beat: x1, x2, x4, x8
	typedef logic [1:0] cps_width_t;
	typedef struct packed {
		logic valid;
		logic is_ram;
		logic [6:0] ecc;
		logic [31:0] data;
	} cps_rb_t;
	typedef struct packed {
		logic single_fix;
		logic multi_err;
		logic crc_err;
		logic [15:0] frame;
	} cps_rpt_t;
endpackage
`default_nettype wire

// ===== core/cps_config_ctrl.sv
// Purpose: configuration port selection, image loading, boot fallback, scrubbing
// Assumes: pins are asynchronous and pass two flops; tap commands and readback are on clk
// Notes: slave serial port cannot be stalled, so fifo overrun is reported as a fault
// Contract
// - at power-up the program-select level picks the configuration port.
// - while program-select is low the slave ports listen for an activation key.
// - with no slave port activated when program-select is high, boot as master from boot memory.
// - an activated port stays selected until the configuration cycle ends or the scan port takes over.
// - the scan port becomes active any time after power-up on scan enable plus tap command.
// - master boot supports x1, x2 and x4 boot memories.
// - the tap loads one bit wide; the slave serial port loads x1, x4 or x8.
// - scan enable is dedicated; init and done pins may become general io.
// - a faulty new image makes the device fall back to the golden image and retry (master boot only; a faulty slave or scan image ends in fail).
// - the scrubber reads configuration memory frame by frame with an ecc check.
// - a single-bit error is notified, written back corrected, and scanning goes on.
// - more than one bad bit in a frame gives an error report, not a correction.
// - after all frames a crc over the whole image is checked, accumulated alongside.
// - ram contents are read back but skipped by ecc and crc.
// - boundary cells form a chain that shifts, applies and captures test data.
`include "cps_map.svh"
`default_nettype none

// ***********************************
// stream fifo
// ***********************************
module cps_fifo #(parameter int WIDTH = 8, parameter int DEPTH = 16) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg, rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push, pop;
	assign in_ready = count_reg != (AW+1)'(DEPTH);
	assign out_valid = count_reg != '0;
	assign out_data = mem[rd_ptr_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // cps_fifo

// ***********************************
// top
// ***********************************
module cps_config_ctrl import cps_pkg::*; #(
	parameter logic [31:0] KEY = `CPS_KEY_DEFAULT,
	parameter logic [7:0] VERSION = `CPS_VERSION_DEFAULT,
	parameter int IMAGE_BYTES = 64,
	parameter int FRAMES = 8,
	parameter int FRAME_WORDS = 4,
	parameter int BSC_LEN = 8,
	parameter int FIFO_DEPTH = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// configuration pins
	input wire logic program_select_pin,
	input wire logic slave_chip_select_n,
	input wire logic slave_sclk,
	input wire logic [7:0] slave_data,
	input wire logic scan_enable_pin,
	output logic init_status_pin,
	output logic done_pin,
	// straps and pin reuse
	input wire cps_width_t slave_width,
	input wire cps_width_t boot_width,
	input wire logic [1:0] gpio_reassign,
	input wire logic [1:0] gpio_value,
	// i2c and i3c slave front ends
	input wire logic i2c_key_ok,
	input wire logic i3c_key_ok,
	input wire logic bus_byte_valid,
	input wire logic [7:0] bus_byte,
	// boot memory
	output logic boot_clk,
	output logic boot_cs_n,
	output logic [3:0] boot_dq_o,
	output logic [3:0] boot_dq_oe,
	input wire logic [3:0] boot_dq_i,
	// test access
	input wire logic tck,
	input wire logic tdi,
	input wire logic tap_cfg_cmd,
	input wire logic scan_capture,
	input wire logic scan_shift,
	input wire logic scan_update,
	input wire logic [BSC_LEN-1:0] probe_in,
	output logic tdo,
	output logic [BSC_LEN-1:0] probe_out,
	// configuration memory write
	output logic cfg_wr_valid,
	input wire logic cfg_wr_ready,
	output logic [7:0] cfg_wr_data,
	output logic [15:0] cfg_wr_addr,
	// scrubber
	input wire logic scrub_en,
	input wire logic [31:0] expected_crc,
	output logic rb_req,
	output logic [15:0] rb_addr,
	input wire cps_rb_t rb,
	output logic wb_en,
	output logic [38:0] wb_word,
	output cps_rpt_t scrub_rpt,
	output logic scrub_event,
	// status
	output cps_port_t active_port,
	output logic golden_sel,
	output logic config_fault
);
	localparam int HALF = `CPS_BOOT_HALF;
	function automatic logic [3:0] wbits(input cps_width_t w);
		return 4'h1 << w;
	endfunction
	function automatic logic [6:0] ecc_of(input logic [31:0] d);
		logic [6:0] e;
		e = '0;
		for (int i = 0; i < 32; i++) begin
			if (d[i]) e[5:0] = e[5:0] ^ 6'(i + 1);
		end
		e[6] = ^d;
		return e;
	endfunction
	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 31; i >= 0; i--) begin
			r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? `CPS_CRC_POLY : 32'h0);
		end
		return r;
	endfunction

	// ***********************************
	// pin synchronisers
	// ***********************************
	logic [17:0] sync1_reg, sync2_reg, last_reg;
	// no reset: both stages must already hold the pin levels when the power-up cycle reads them
	always_ff @(posedge clk) begin
		sync1_reg <= {slave_chip_select_n, program_select_pin, scan_enable_pin, tck, tdi,
			slave_sclk, slave_data, boot_dq_i};
		sync2_reg <= sync1_reg;
	end
	always_ff @(posedge clk) begin
		if (!rst_b) last_reg <= 18'h3_0000;
		else last_reg <= sync2_reg;
	end
	logic cs_n_s, prog_s, scan_en_s, tdi_s, cs_rise, tck_rise, sclk_rise;
	logic [7:0] sdata_s;
	logic [3:0] dq_s;
	assign {cs_n_s, prog_s, scan_en_s} = sync2_reg[17:15];
	assign tdi_s = sync2_reg[13];
	assign sdata_s = sync2_reg[11:4];
	assign dq_s = sync2_reg[3:0];
	assign cs_rise = cs_n_s && !last_reg[17];
	assign tck_rise = sync2_reg[14] && !last_reg[14];
	assign sclk_rise = sync2_reg[12] && !last_reg[12];

	// ***********************************
	// port selection
	// ***********************************
	cps_state_t state_reg;
	cps_width_t swidth_reg, bwidth_reg;
	logic [31:0] key_reg;
	logic [15:0] byte_cnt_reg;
	logic image_ok, drained, fifo_in_ready, byte_stb_reg, overrun_reg;
	logic [7:0] byte_reg, sum_reg, ver_reg;
	logic scan_go;
	assign scan_go = scan_en_s && tap_cfg_cmd && state_reg != ST_POR;
	assign image_ok = sum_reg == 8'h00 && ver_reg == VERSION && !overrun_reg;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_reg <= ST_POR;
			active_port <= PORT_NONE;
			golden_sel <= 1'b0;
			swidth_reg <= 2'h0;
			bwidth_reg <= 2'h0;
		end else if (scan_go) begin
			state_reg <= ST_SCAN;
			active_port <= PORT_SCAN;
		end else begin
			unique case (state_reg)
				ST_POR: begin
					swidth_reg <= (slave_width == 2'h1) ? 2'h0 : slave_width;
					bwidth_reg <= (boot_width == 2'h3) ? 2'h2 : boot_width;
					state_reg <= prog_s ? ST_MASTER : ST_SLAVE_WAIT;
					active_port <= prog_s ? PORT_MASTER : PORT_NONE;
				end
				ST_SLAVE_WAIT: begin
					if (cs_rise && key_reg == KEY) begin
						state_reg <= ST_SLAVE_LOAD;
						active_port <= PORT_SERIAL;
					end else if (i2c_key_ok || i3c_key_ok) begin
						state_reg <= ST_SLAVE_LOAD;
						active_port <= i2c_key_ok ? PORT_I2C : PORT_I3C;
					end else if (prog_s) begin
						state_reg <= ST_MASTER;
						active_port <= PORT_MASTER;
					end
				end
				ST_SLAVE_LOAD, ST_MASTER, ST_SCAN: begin
					if (byte_cnt_reg == 16'(IMAGE_BYTES)) state_reg <= ST_FINISH;
				end
				ST_FINISH: begin
					if (drained) begin
						if (image_ok) begin
							state_reg <= ST_USER;
						end else if (active_port == PORT_MASTER && !golden_sel) begin
							golden_sel <= 1'b1;
							state_reg <= ST_MASTER;
						end else begin
							state_reg <= ST_FAIL;
						end
					end
				end
				ST_USER, ST_FAIL: state_reg <= state_reg;
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_b) key_reg <= '0;
		else if (state_reg == ST_SLAVE_WAIT && byte_stb_reg) key_reg <= {key_reg[23:0], byte_reg};
	end

	// ***********************************
	// master boot engine
	// ***********************************
	logic [7:0] div_reg;
	logic [5:0] cmd_cnt_reg;
	logic [31:0] cmd_reg;
	logic tick, mrise, mfall, mload;
	assign mload = state_reg == ST_MASTER && byte_cnt_reg != 16'(IMAGE_BYTES);
	// clock pauses while the fifo is full so the boot memory is back-pressured
	assign tick = mload && fifo_in_ready && div_reg == 8'(HALF - 1);
	assign mrise = tick && !boot_clk;
	assign mfall = tick && boot_clk;
	always_ff @(posedge clk) begin
		if (!rst_b || !mload || tick) div_reg <= '0;
		else if (fifo_in_ready) div_reg <= div_reg + 8'h1;
	end
	always_ff @(posedge clk) begin
		if (!rst_b || !mload) begin
			boot_clk <= 1'b0;
			boot_cs_n <= 1'b1;
			boot_dq_o <= '0;
			boot_dq_oe <= '0;
			cmd_cnt_reg <= '0;
			// a retry leaves finish with golden_sel still low, so finish already loads the golden address
			cmd_reg <= {`CPS_READ_CMD, (golden_sel || state_reg == ST_FINISH) ? `CPS_GOLDEN_ADDR : `CPS_PRIMARY_ADDR};
		end else begin
			boot_cs_n <= 1'b0;
			if (tick && !boot_cs_n) boot_clk <= !boot_clk;
			if (mfall || (boot_cs_n && cmd_cnt_reg == 6'h0)) begin
				if (cmd_cnt_reg != `CPS_CMD_BITS) begin
					boot_dq_o <= {3'h0, cmd_reg[31]};
					boot_dq_oe <= 4'h1;
					cmd_reg <= {cmd_reg[30:0], 1'b0};
					cmd_cnt_reg <= cmd_cnt_reg + 6'h1;
				end else begin
					boot_dq_oe <= 4'h0;
				end
			end
		end
	end

	// ***********************************
	// byte assembly from every source
	// ***********************************
	logic in_stb;
	logic [7:0] in_bits;
	cps_width_t in_w;
	logic [7:0] asm_reg;
	logic [3:0] asm_cnt_reg;
	always_comb begin
		in_stb = 1'b0;
		in_bits = 8'h0;
		in_w = 2'h0;
		unique case (state_reg)
			ST_SLAVE_WAIT, ST_SLAVE_LOAD: begin
				in_stb = sclk_rise && !cs_n_s && active_port != PORT_I2C && active_port != PORT_I3C;
				in_w = swidth_reg;
				in_bits = sdata_s;
			end
			ST_MASTER: begin
				in_stb = mrise && cmd_cnt_reg == `CPS_CMD_BITS && boot_dq_oe == 4'h0;
				in_w = bwidth_reg;
				in_bits = (bwidth_reg == 2'h0) ? {7'h0, dq_s[1]} : {4'h0, dq_s};
			end
			ST_SCAN: begin
				in_stb = tck_rise && scan_shift;
				in_bits = {7'h0, tdi_s};
			end
			default: ;
		endcase
	end
	always_ff @(posedge clk) begin
		if (!rst_b || state_reg == ST_POR || scan_go) begin
			asm_reg <= '0;
			asm_cnt_reg <= '0;
			byte_stb_reg <= 1'b0;
			byte_reg <= '0;
		end else begin
			byte_stb_reg <= 1'b0;
			if ((active_port == PORT_I2C || active_port == PORT_I3C) && bus_byte_valid) begin
				byte_stb_reg <= 1'b1;
				byte_reg <= bus_byte;
			end else if (in_stb) begin
				asm_reg <= 8'(asm_reg << wbits(in_w)) | (in_bits & 8'(8'hff >> (4'h8 - wbits(in_w))));
				if (asm_cnt_reg + wbits(in_w) == 4'h8) begin
					byte_stb_reg <= 1'b1;
					byte_reg <= 8'(asm_reg << wbits(in_w)) | (in_bits & 8'(8'hff >> (4'h8 - wbits(in_w))));
					asm_cnt_reg <= '0;
				end else begin
					asm_cnt_reg <= asm_cnt_reg + wbits(in_w);
				end
			end
		end
	end

	// ***********************************
	// image stream and checks
	// ***********************************
	logic loading, push, fifo_out_valid, fifo_out_ready;
	logic [7:0] fifo_out_data;
	assign loading = state_reg inside {ST_SLAVE_LOAD, ST_MASTER, ST_SCAN};
	assign push = loading && byte_stb_reg && byte_cnt_reg != 16'(IMAGE_BYTES);
	assign fifo_out_ready = !cfg_wr_valid || cfg_wr_ready;
	assign drained = !fifo_out_valid && !cfg_wr_valid;
	always_ff @(posedge clk) begin
		// cleared at image end so a golden retry counts and checks from zero
		if (!rst_b || !(loading || state_reg == ST_FINISH) || (state_reg == ST_FINISH && drained)) begin
			byte_cnt_reg <= '0;
			sum_reg <= '0;
			ver_reg <= '0;
			overrun_reg <= 1'b0;
		end else if (push) begin
			byte_cnt_reg <= byte_cnt_reg + 16'h1;
			sum_reg <= sum_reg ^ byte_reg;
			if (byte_cnt_reg == 16'h0) ver_reg <= byte_reg;
			if (!fifo_in_ready) overrun_reg <= 1'b1;
		end
	end
	cps_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(byte_reg),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cfg_wr_valid <= 1'b0;
			cfg_wr_data <= '0;
			cfg_wr_addr <= '0;
		end else begin
			if (cfg_wr_valid && cfg_wr_ready) cfg_wr_addr <= cfg_wr_addr + 16'h1;
			if (state_reg == ST_POR || (state_reg == ST_FINISH && drained)) cfg_wr_addr <= '0;
			if (fifo_out_ready) begin
				cfg_wr_valid <= fifo_out_valid;
				cfg_wr_data <= fifo_out_data;
			end
		end
	end
	// pins given over to general io show the user value once configured
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			done_pin <= 1'b0;
			init_status_pin <= 1'b1;
			config_fault <= 1'b0;
		end else begin
			config_fault <= state_reg == ST_FAIL;
			done_pin <= (state_reg == ST_USER && gpio_reassign[0]) ? gpio_value[0] : state_reg == ST_USER;
			init_status_pin <= (state_reg == ST_USER && gpio_reassign[1]) ? gpio_value[1] : state_reg != ST_FAIL;
		end
	end

	// ***********************************
	// boundary scan chain
	// ***********************************
	logic [BSC_LEN-1:0] bsc_reg;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			bsc_reg <= '0;
			probe_out <= '0;
			tdo <= 1'b0;
		end else begin
			if (scan_capture) bsc_reg <= probe_in;
			else if (tck_rise && scan_shift && state_reg != ST_SCAN) bsc_reg <= {tdi_s, bsc_reg[BSC_LEN-1:1]};
			if (scan_update) probe_out <= bsc_reg;
			tdo <= bsc_reg[0];
		end
	end

	// ***********************************
	// soft error scrubber
	// ***********************************
	cps_scrub_t sc_reg;
	logic [15:0] frame_reg;
	logic [7:0] word_reg;
	logic [31:0] crc_reg;
	logic [1:0] frame_errs_reg;
	logic [6:0] syn;
	logic last_word;
	assign syn = ecc_of(rb.data) ^ rb.ecc;
	assign last_word = word_reg == 8'(FRAME_WORDS - 1);
	always_ff @(posedge clk) begin
		if (!rst_b || state_reg != ST_USER || !scrub_en) begin
			sc_reg <= SC_IDLE;
			frame_reg <= '0;
			word_reg <= '0;
			crc_reg <= `CPS_CRC_INIT;
			frame_errs_reg <= '0;
			rb_req <= 1'b0;
			rb_addr <= '0;
			wb_en <= 1'b0;
			wb_word <= '0;
			scrub_rpt <= '0;
			scrub_event <= 1'b0;
		end else begin
			rb_req <= 1'b0;
			wb_en <= 1'b0;
			scrub_event <= 1'b0;
			unique case (sc_reg)
				SC_IDLE: sc_reg <= SC_READ;
				SC_READ: begin
					rb_req <= 1'b1;
					rb_addr <= 16'(frame_reg * 16'(FRAME_WORDS)) + 16'(word_reg);
					sc_reg <= SC_WAIT;
				end
				SC_WAIT: if (rb.valid) begin
					if (!rb.is_ram) begin
						crc_reg <= crc_step(crc_reg, rb.data);
						if (syn[6] && frame_errs_reg == 2'h0) begin
							wb_en <= 1'b1;
							wb_word <= {ecc_of(rb.data ^ ((syn[5:0] != 6'h0 && syn[5:0] <= 6'd32) ?
								32'h1 << (syn[5:0] - 6'h1) : 32'h0)),
								rb.data ^ ((syn[5:0] != 6'h0 && syn[5:0] <= 6'd32) ? 32'h1 << (syn[5:0] - 6'h1) : 32'h0)};
							scrub_rpt <= '{single_fix: 1'b1, multi_err: 1'b0, crc_err: 1'b0, frame: frame_reg};
							scrub_event <= 1'b1;
							frame_errs_reg <= 2'h1;
						end else if (syn != 7'h0) begin
							scrub_rpt <= '{single_fix: 1'b0, multi_err: 1'b1, crc_err: 1'b0, frame: frame_reg};
							scrub_event <= 1'b1;
							frame_errs_reg <= 2'h2;
						end
					end
					word_reg <= last_word ? 8'h0 : word_reg + 8'h1;
					if (last_word) begin
						frame_errs_reg <= '0;
						frame_reg <= frame_reg + 16'h1;
					end
					sc_reg <= (last_word && frame_reg == 16'(FRAMES - 1)) ? SC_CRC : SC_READ;
				end
				SC_CRC: begin
					scrub_rpt <= '{single_fix: 1'b0, multi_err: 1'b0, crc_err: crc_reg != expected_crc, frame: 16'h0};
					scrub_event <= crc_reg != expected_crc;
					crc_reg <= `CPS_CRC_INIT;
					frame_reg <= '0;
					sc_reg <= SC_READ;
				end
				default: sc_reg <= SC_IDLE;
			endcase
		end
	end
endmodule // cps_config_ctrl
`default_nettype wire

// ===== bench/cps_config_props.sv
// Purpose: port assertions for the configuration controller
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to every instance of the top module
`default_nettype none
// ***
// checker
// ***
module cps_config_props import cps_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// boot memory
	input wire logic boot_clk,
	input wire logic boot_cs_n,
	input wire logic [3:0] boot_dq_oe,
	// write stream
	input wire logic cfg_wr_valid,
	input wire logic cfg_wr_ready,
	input wire logic [7:0] cfg_wr_data,
	input wire logic [15:0] cfg_wr_addr,
	// scrubber and status
	input wire logic wb_en,
	input wire cps_rpt_t scrub_rpt,
	input wire logic scrub_event,
	input wire cps_port_t active_port,
	input wire logic golden_sel
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_cs_master: assert property (!boot_cs_n |-> active_port == PORT_MASTER)
		else $error("boot memory selected outside master boot");
	a_cmd_driven: assert property ($fell(boot_cs_n) |-> boot_dq_oe[0])
		else $error("command line not driven at boot start");
	a_slave_quiet: assert property (active_port inside {PORT_SERIAL, PORT_I2C, PORT_I3C} |-> boot_cs_n)
		else $error("boot memory touched while a slave port is active");
	a_port_stable: assert property (cfg_wr_valid && $past(cfg_wr_valid) && active_port != PORT_SCAN |-> $stable(active_port))
		else $error("active port changed during loading");
	a_wr_hold: assert property (cfg_wr_valid && !cfg_wr_ready |=> cfg_wr_valid && $stable(cfg_wr_data) && $stable(cfg_wr_addr))
		else $error("write stream dropped before ready");
	a_addr_step: assert property (cfg_wr_valid && cfg_wr_ready |=> cfg_wr_addr == $past(cfg_wr_addr) + 16'h1 || cfg_wr_addr == 16'h0)
		else $error("write address did not step");
	a_boot_clk_half: assert property (!boot_cs_n && $changed(boot_clk) |=> ($stable(boot_clk) || boot_cs_n) [*3])
		else $error("boot clock half period too short");
	a_golden_retry: assert property ($rose(golden_sel) |-> ##[0:40] $fell(boot_cs_n))
		else $error("no retry from the golden image");
	a_fix_reported: assert property (wb_en |-> ##[0:2] (scrub_event && scrub_rpt.single_fix))
		else $error("write-back without single-fix report");
	a_multi_nofix: assert property (scrub_event && scrub_rpt.multi_err |-> !wb_en && !scrub_rpt.single_fix)
		else $error("multi-bit error was corrected");
endmodule // cps_config_props

bind cps_config_ctrl cps_config_props u_cps_config_props (.clk, .rst_b, .boot_clk, .boot_cs_n, .boot_dq_oe,
	.cfg_wr_valid, .cfg_wr_ready, .cfg_wr_data, .cfg_wr_addr, .wb_en, .scrub_rpt, .scrub_event, .active_port,
	.golden_sel);
`default_nettype wire

// ===== bench/cps_boot_mem.sv
// Purpose: serial boot memory model
// Assumes: 8-bit command and 24-bit address, msb first on dq0
// Notes: primary image may carry a wrong version byte
`default_nettype none
// ***
// boot memory
// ***
module cps_boot_mem (
	// pins
	input wire logic boot_clk,
	input wire logic boot_cs_n,
	input wire logic [3:0] boot_dq_o,
	output logic [3:0] dq,
	// straps
	input wire logic [1:0] width,
	input wire logic bad_primary
);
	timeunit 1ns;
	timeprecision 100ps;
	int n = 0;
	int k;
	int w;
	logic [7:0] by;
	logic [31:0] hdr = 32'h0;
	initial dq = 4'h0;
	assign w = (width == 2'h0) ? 1 : (width == 2'h1) ? 2 : 4;
	function automatic logic [7:0] img_byte(input int i, input logic [7:0] ver);
		// bytes 1..62 xor to 8'h3f, so the last byte balances the image
		return (i == 0) ? ver : (i == 63) ? (ver ^ 8'h3f) : i[7:0];
	endfunction
	always @(posedge boot_clk or posedge boot_cs_n) begin
		if (boot_cs_n) n <= 0;
		else begin
			if (n < 32) hdr <= {hdr[30:0], boot_dq_o[0]};
			n <= n + 1;
		end
	end
	// released lines toggle so a stale value is never read as data
	always @(negedge boot_clk or posedge boot_cs_n) begin
		if (boot_cs_n) dq <= ~dq;
		else if (n >= 32) begin
			k = (n - 32) * w;
			by = img_byte(k / 8, (hdr[23:0] == 24'h0 && bad_primary) ? 8'h02 : 8'h01);
			dq <= ~dq;
			if (w == 1) dq[1] <= by[7 - k % 8];
			else for (int j = 0; j < w; j++) dq[w - 1 - j] <= by[7 - k % 8 - j];
		end
	end
endmodule // cps_boot_mem
`default_nettype wire

// ===== bench/cps_config_ctrl_tb.sv
// Purpose: self-checking bench for the configuration controller
// Assumes: 50 MHz clock, slave clock 160 ns
// Notes: readback answers one cycle after each request
`include "cps_map.svh"
`default_nettype none
// ***
// bench
// ***
module cps_config_ctrl_tb import cps_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic program_select_pin = 1'b0, slave_chip_select_n = 1'b1, slave_sclk = 1'b0, scan_enable_pin = 1'b0;
	logic [7:0] slave_data = 8'h00, bus_byte = 8'h00, probe_in = 8'ha5, probe_out, cfg_wr_data;
	cps_width_t slave_width = 2'h0, boot_width = 2'h0;
	logic [1:0] gpio_reassign = 2'h0, gpio_value = 2'h0;
	logic i2c_key_ok = 1'b0, i3c_key_ok = 1'b0, bus_byte_valid = 1'b0, tck = 1'b0, tdi = 1'b0;
	logic tap_cfg_cmd = 1'b0, scan_capture = 1'b0, scan_shift = 1'b0, scan_update = 1'b0, bad_primary = 1'b0;
	logic init_status_pin, done_pin, boot_clk, boot_cs_n, tdo, cfg_wr_valid, cfg_wr_ready = 1'b1;
	logic scrub_en = 1'b0, rb_req, wb_en, scrub_event, golden_sel, config_fault;
	logic [3:0] boot_dq_o, boot_dq_oe, boot_dq_i;
	logic [15:0] cfg_wr_addr, rb_addr;
	logic [31:0] expected_crc = 32'h1234_5678;
	logic [38:0] wb_word;
	cps_rb_t rb = '0;
	cps_rpt_t scrub_rpt;
	cps_port_t active_port;
	int miscompares = 0, checked = 0, nt = 0;
	logic [23:0] got[$];
	cps_rpt_t ev[$];
	logic [38:0] wbq[$];
	cps_config_ctrl u_cps_config_ctrl (.*);
	cps_boot_mem u_cps_boot_mem (.boot_clk(boot_clk), .boot_cs_n(boot_cs_n), .boot_dq_o(boot_dq_o),
		.dq(boot_dq_i), .width(boot_width), .bad_primary(bad_primary));
	always #10 clk = ~clk;
	always @(posedge boot_clk) nt++;
	always @(posedge clk) begin
		if (cfg_wr_valid && cfg_wr_ready) got.push_back({cfg_wr_addr, cfg_wr_data});
		if (scrub_event) ev.push_back(scrub_rpt);
		if (wb_en) wbq.push_back(wb_word);
		rb <= rb_req ? cps_rb_t'{valid: 1'b1, is_ram: rb_addr == 16'd12, ecc: 7'h0,
			data: (rb_addr == 16'd5) ? 32'h8 : (rb_addr == 16'd9) ? 32'h6 : (rb_addr == 16'd12) ? '1 : 32'h0} : '0;
	end
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		if (miscompares == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic do_reset(input logic psel, input cps_width_t bw, input logic bad);
		@(posedge clk);
		rst_b <= 1'b0;
		program_select_pin <= psel;
		boot_width <= bw;
		bad_primary <= bad;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
	task automatic t_slave_scan();
		do_reset(1'b0, 2'h0, 1'b0);
		slave_chip_select_n <= 1'b0;
		for (int i = 31; i >= 0; i--) begin
			slave_data[0] <= `CPS_KEY_DEFAULT >> i;
			repeat (4) @(posedge clk);
			slave_sclk <= 1'b1;
			repeat (4) @(posedge clk);
			slave_sclk <= 1'b0;
		end
		slave_chip_select_n <= 1'b1;
		program_select_pin <= 1'b1;
		repeat (200) @(posedge clk);
		check("slave port", active_port, PORT_SERIAL);
		check("boot idle", boot_cs_n, 1'b1);
		scan_capture <= 1'b1;
		@(posedge clk);
		scan_capture <= 1'b0;
		repeat (3) @(posedge clk);
		check("capture", tdo, probe_in[0]);
		scan_enable_pin <= 1'b1;
		repeat (4) @(posedge clk);
		tap_cfg_cmd <= 1'b1;
		@(posedge clk);
		tap_cfg_cmd <= 1'b0;
		repeat (4) @(posedge clk);
		check("scan port", active_port, PORT_SCAN);
		scan_enable_pin <= 1'b0;
	endtask
	task automatic t_i2c();
		do_reset(1'b0, 2'h0, 1'b0);
		got.delete();
		i2c_key_ok <= 1'b1;
		@(posedge clk);
		i2c_key_ok <= 1'b0;
		bus_byte_valid <= 1'b1;
		bus_byte <= 8'h5a;
		@(posedge clk);
		bus_byte_valid <= 1'b0;
		repeat (8) @(posedge clk);
		check("i2c port", active_port, PORT_I2C);
		check("i2c bytes", got.size(), 1);
		check("i2c byte", got[0], 24'h00_005a);
	endtask
	task automatic t_master(input cps_width_t bw, input logic bad);
		int t0;
		do_reset(1'b1, bw, bad);
		got.delete();
		check("master port", active_port, PORT_MASTER);
		cfg_wr_ready <= 1'b0;
		// long enough at x1 for the command plus 17 bytes to fill the fifo and the write stage
		repeat (1600) @(posedge clk);
		t0 = nt;
		repeat (100) @(posedge clk);
		check("full fifo pauses boot", nt - t0, 0);
		cfg_wr_ready <= 1'b1;
		for (int i = 0; i < 30000 && done_pin !== 1'b1; i++) @(posedge clk);
		check("done", done_pin, 1'b1);
		check("read cmd", u_cps_boot_mem.hdr, {`CPS_READ_CMD, bad ? `CPS_GOLDEN_ADDR : `CPS_PRIMARY_ADDR});
		check("golden", golden_sel, bad);
		check("no fault", config_fault, 1'b0);
		check("bytes", got.size(), bad ? 128 : 64);
		for (int i = 0; i < 64; i++)
			check("image", got[got.size() - 64 + i], {i[15:0], u_cps_boot_mem.img_byte(i, `CPS_VERSION_DEFAULT)});
	endtask
	task automatic t_scrub();
		ev.delete();
		wbq.delete();
		scrub_en <= 1'b1;
		for (int i = 0; i < 5000 && !(ev.size() > 0 && ev[$].crc_err); i++) @(posedge clk);
		for (int i = 0; i < 50 && rb_req !== 1'b1; i++) @(posedge clk);
		check("restart", rb_addr, 16'h0);
		scrub_en <= 1'b0;
		gpio_reassign <= 2'h3;
		repeat (3) @(posedge clk);
		check("gpio done", done_pin, 1'b0);
		check("gpio init", init_status_pin, 1'b0);
		gpio_reassign <= 2'h0;
		check("events", ev.size(), 3);
		check("single", ev[0], {3'b100, 16'd1});
		check("multi", ev[1], {3'b010, 16'd2});
		check("crc", ev[2].crc_err, 1'b1);
		check("fixes", wbq.size(), 1);
		check("fixed word", wbq[0], 39'h0);
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		print_verdict();
	end
	initial begin
		t_slave_scan();
		t_i2c();
		t_master(2'h2, 1'b0);
		t_scrub();
		t_master(2'h1, 1'b0);
		t_master(2'h0, 1'b1);
		print_verdict();
	end
endmodule // cps_config_ctrl_tb
`default_nettype wire
